//--- rtl/pmc_pkg.sv
// Package of constants and types for the positioner mode controller.
// Assumes a single 25 MHz system clock shared by all design files.
package pmc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned STEP_TIME_US   = 1000;
  localparam int unsigned STEP_CYCLES    = (CLK_HZ / 1000000) * STEP_TIME_US;
  localparam int unsigned BLINK_TIME_MS  = 250;
  localparam int unsigned BLINK_CYCLES   = (CLK_HZ / 1000) * BLINK_TIME_MS;
  localparam int unsigned TMO_WIDTH      = 32;

  // ----------------------------------------------------------------
  // Self-test and alert layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TESTS      = 4;
  localparam int unsigned TEST_W         = 3;
  localparam int unsigned NUM_ALERTS     = 8;
  localparam int unsigned ALERT_IDX_W    = 3;
  localparam int unsigned VAL_W          = 16;
  localparam int unsigned BLINK_W        = 24;
  localparam logic [3:0]  GREEN_ALL_OFF  = 4'h0;
  localparam logic [3:0]  GREEN_ALL_ON   = 4'hf;

  // ----------------------------------------------------------------
  // Failure actions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_ACT_HOLD   = 2'h0,
    PMC_ACT_VENT   = 2'h1,
    PMC_ACT_PRESET = 2'h2
  } pmc_action_t;

  // ----------------------------------------------------------------
  // Operating modes, Gray coded along the start-up path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_POWER_ON_CHECK     = 3'h0,
    PMC_IDLE_UNCONFIGURED  = 3'h1,
    PMC_SELF_TUNING        = 3'h3,
    PMC_NORMAL_CONTROL     = 3'h2,
    PMC_SETPOINT_LOSS_SAFE = 3'h6,
    PMC_TEST_FAILED        = 3'h7,
    PMC_FATAL_ERROR_HALT   = 3'h5
  } pmc_mode_t;

  // ----------------------------------------------------------------
  // Display selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_DISP_ALERT    = 2'h0,
    PMC_DISP_MEASURED = 2'h1,
    PMC_DISP_MENU     = 2'h2
  } pmc_disp_t;

endpackage

//--- rtl/pmc_alert_if.sv
// Interface carrying alert navigation signals between mode controller and alert viewer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface pmc_alert_if;
  logic [pmc_pkg::NUM_ALERTS-1:0]  pending;
  logic                            key_up;
  logic                            key_down;
  logic                            key_menu;
  logic                            active;
  logic                            any;
  logic [pmc_pkg::ALERT_IDX_W-1:0] idx;
  pmc_pkg::pmc_disp_t              disp;

  modport ctrl (output pending, output key_up, output key_down, output key_menu, output active,
                input any, input idx, input disp);
  modport view (input pending, input key_up, input key_down, input key_menu, input active,
                output any, output idx, output disp);
endinterface

//--- rtl/pmc_alert_view.sv
// Alert viewer: picks the highest-priority pending alert and steps through them by key.
// Assumes key inputs are single-cycle press pulses; bit 0 has the highest priority.
`timescale 1ns/1ps
module pmc_alert_view (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Alert navigation
  pmc_alert_if.view ai
);

  logic [pmc_pkg::ALERT_IDX_W-1:0] idx_ff;
  logic [pmc_pkg::ALERT_IDX_W-1:0] nxt_idx;
  logic [pmc_pkg::ALERT_IDX_W-1:0] top_idx;
  logic [pmc_pkg::ALERT_IDX_W-1:0] next_idx;
  logic                            next_found;
  pmc_pkg::pmc_disp_t              disp_ff;
  pmc_pkg::pmc_disp_t              nxt_disp;

  // ----------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------
  always_comb begin
    top_idx    = '0;
    next_idx   = top_idx;
    next_found = 1'b0;
    for (int i = pmc_pkg::NUM_ALERTS - 1; i >= 0; i--) begin
      if (ai.pending[i]) begin
        top_idx = i[pmc_pkg::ALERT_IDX_W-1:0];
      end
    end
    next_idx = top_idx;
    for (int i = pmc_pkg::NUM_ALERTS - 1; i >= 0; i--) begin
      if (ai.pending[i] && (i[pmc_pkg::ALERT_IDX_W-1:0] > idx_ff)) begin
        next_idx   = i[pmc_pkg::ALERT_IDX_W-1:0];
        next_found = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Navigation
  // ----------------------------------------------------------------
  always_comb begin
    nxt_idx  = idx_ff;
    nxt_disp = disp_ff;
    if (!ai.active || !(|ai.pending)) begin
      nxt_idx  = top_idx;
      nxt_disp = pmc_pkg::PMC_DISP_ALERT;
    end else if (ai.key_menu) begin
      nxt_disp = pmc_pkg::PMC_DISP_MENU;
    end else if (ai.key_up) begin
      nxt_disp = pmc_pkg::PMC_DISP_MEASURED;
    end else if (ai.key_down) begin
      nxt_idx  = next_found ? next_idx : top_idx;
      nxt_disp = pmc_pkg::PMC_DISP_ALERT;
    end else if (!ai.pending[idx_ff]) begin
      nxt_idx = top_idx;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_ff  <= '0;
      disp_ff <= pmc_pkg::PMC_DISP_ALERT;
    end else begin
      idx_ff  <= nxt_idx;
      disp_ff <= nxt_disp;
    end
  end

  assign ai.idx  = idx_ff;
  assign ai.disp = disp_ff;
  assign ai.any  = |ai.pending;

endmodule

//--- rtl/pmc_mode_ctrl.sv
// Operating-mode controller of a valve positioner with alert display and key handling.
// Assumes synchronous inputs on sys_clk, keys as levels, and a retained tuned flag outside.
`timescale 1ns/1ps

// Overview of operation
// - After reset, self-tests run in sequence with each step shown on LEDs.
// - Tests pass and never tuned: enter idle_unconfigured.
// - Tests pass and tuned before: enter normal_control.
// - Start-up test failure halts, showing the failing test code.
// - Cyclic fault enters fatal halt (a tuned idle device given a bus setpoint that cycle goes to normal_control): red steady, greens off, message shown.
// - Completed tuning enters normal_control and is remembered across resets.
// - Setpoints received over the link put a tuned idle device in normal_control.
// - Fieldbus setpoint timeout enters safe mode with the configured action.
// - Cyclic self-diagnosis keeps running while in safe mode.
// - A new setpoint in safe mode returns to normal_control at once.
// - Untuned device stays idle until the operator starts a tuning run.
// - Menu entry is always enabled while idle_unconfigured.
// - Factory restore clears the tuned flag so start-up lands in idle.
// - Tuning runs in self_tuning mode, then enters normal_control.
// - Supervised problems raise alerts on the display or a blink pattern.
// - Highest alert first; DOWN steps onward, UP shows measured values.
// - Menu keys open the menu while alerts are shown, except in power-on check and fatal halt.
// - Position override replaces reported position only when enabled, fieldbus only.
// - Analog variant uses digitised loop current as setpoint, else the bus.
// - I/O option gives binary outputs, current output with alarm, force inputs.
module pmc_mode_ctrl (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rstn,
  // Local keys, held levels
  input  wire logic                            key_up,
  input  wire logic                            key_down,
  input  wire logic                            key_menu,
  // Self-test results
  input  wire logic                            test_done,
  input  wire logic                            test_pass,
  input  wire logic                            cyclic_fault,
  // Retained tuning status and commands
  input  wire logic                            tuned_stored,
  input  wire logic                            tune_start,
  input  wire logic                            tune_done,
  input  wire logic                            factory_restore,
  // Setpoint sources and configuration
  input  wire logic                            fieldbus_variant,
  input  wire logic [pmc_pkg::VAL_W-1:0]       adc_setpoint,
  input  wire logic                            bus_sp_valid,
  input  wire logic [pmc_pkg::VAL_W-1:0]       bus_setpoint,
  input  wire logic [pmc_pkg::TMO_WIDTH-1:0]   sp_timeout_cycles,
  input  wire pmc_pkg::pmc_action_t            fail_action,
  input  wire logic [pmc_pkg::VAL_W-1:0]       preset_position,
  // Position override
  input  wire logic                            override_enable,
  input  wire logic                            override_valid,
  input  wire logic [pmc_pkg::VAL_W-1:0]       override_value,
  input  wire logic [pmc_pkg::VAL_W-1:0]       real_position,
  // Supervision and I/O option
  input  wire logic [pmc_pkg::NUM_ALERTS-1:0]  alert_pending,
  input  wire logic                            io_force_open,
  input  wire logic                            io_force_close,
  input  wire logic                            io_hold_last,
  // Mode and display outputs
  output pmc_pkg::pmc_mode_t                   mode,
  output logic                                 tuned_set,
  output logic                                 tuned_clear,
  output logic [pmc_pkg::TEST_W-1:0]           test_step,
  output logic [pmc_pkg::TEST_W-1:0]           fail_code,
  output logic                                 led_red,
  output logic [3:0]                           led_green,
  output logic                                 msg_show,
  output logic                                 menu_enable,
  output pmc_pkg::pmc_disp_t                   disp_sel,
  output logic [pmc_pkg::ALERT_IDX_W-1:0]      alert_idx,
  // Control outputs
  output logic [pmc_pkg::VAL_W-1:0]            ctrl_setpoint,
  output logic                                 vent_output,
  output logic                                 diag_run,
  output logic [pmc_pkg::VAL_W-1:0]            reported_position,
  output logic [1:0]                           io_bin_out,
  output logic                                 io_alarm
);

  pmc_alert_if ai ();

  pmc_pkg::pmc_mode_t              mode_ff;
  pmc_pkg::pmc_mode_t              nxt_mode;
  logic                            kr_ff;
  logic                            srst_ff;
  logic [pmc_pkg::TEST_W-1:0]      step_ff;
  logic [pmc_pkg::TEST_W-1:0]      nxt_step;
  logic [pmc_pkg::TEST_W-1:0]      fcode_ff;
  logic [pmc_pkg::TMO_WIDTH-1:0]   tmo_ff;
  logic [pmc_pkg::TMO_WIDTH-1:0]   nxt_tmo;
  logic [pmc_pkg::VAL_W-1:0]       sp_ff;
  logic [pmc_pkg::VAL_W-1:0]       nxt_sp;
  logic [pmc_pkg::VAL_W-1:0]       ovr_ff;
  logic                            ovr_act_ff;
  logic [pmc_pkg::BLINK_W-1:0]     blink_cnt_ff;
  logic                            blink_ff;
  logic [2:0]                      keys_ff;
  logic                            tuned_set_ff;
  logic                            tuned_clr_ff;
  logic                            red_ff;
  logic [3:0]                      green_ff;
  logic                            msg_ff;
  logic                            menu_ff;
  logic                            vent_ff;
  logic                            diag_ff;
  logic [pmc_pkg::VAL_W-1:0]       rep_ff;
  logic [1:0]                      bin_ff;
  logic                            alarm_ff;
  logic [pmc_pkg::VAL_W-1:0]       ctrl_sp_ff;
  logic                            restore_ok;
  logic                            three_keys;
  logic                            sp_timeout;
  logic                            bus_sp_in;
  logic                            in_safe;
  logic                            blink_wrap;
  logic [2:0]                      key_rise;
  logic [pmc_pkg::VAL_W-1:0]       safe_sp;

  // ----------------------------------------------------------------
  // Three-key reset and key edges
  // ----------------------------------------------------------------
  assign three_keys = key_up && key_down && key_menu;
  assign key_rise   = {key_menu, key_down, key_up} & ~keys_ff;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      kr_ff   <= 1'b0;
      srst_ff <= 1'b1;
      keys_ff <= 3'h0;
    end else begin
      kr_ff   <= three_keys;
      srst_ff <= three_keys && !kr_ff;
      keys_ff <= {key_menu, key_down, key_up};
    end
  end

  // ----------------------------------------------------------------
  // Setpoint path and loss timer
  // ----------------------------------------------------------------
  assign bus_sp_in  = fieldbus_variant && bus_sp_valid;
  assign sp_timeout = fieldbus_variant && (tmo_ff >= sp_timeout_cycles);
  assign in_safe    = (mode_ff == pmc_pkg::PMC_SETPOINT_LOSS_SAFE);
  assign restore_ok = !(mode_ff inside {pmc_pkg::PMC_FATAL_ERROR_HALT, pmc_pkg::PMC_TEST_FAILED});
  assign safe_sp    = (fail_action == pmc_pkg::PMC_ACT_PRESET) ? preset_position : sp_ff;

  always_comb begin
    nxt_tmo = tmo_ff;
    if (bus_sp_in || !fieldbus_variant || mode_ff != pmc_pkg::PMC_NORMAL_CONTROL) begin
      nxt_tmo = '0;
    end else if (!sp_timeout) begin
      nxt_tmo = tmo_ff + 1'b1;
    end
    nxt_sp = sp_ff;
    if (io_hold_last) begin
      nxt_sp = sp_ff;
    end else if (!fieldbus_variant) begin
      nxt_sp = adc_setpoint;
    end else if (bus_sp_in) begin
      nxt_sp = bus_setpoint;
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    nxt_step = step_ff;
    case (mode_ff)
      pmc_pkg::PMC_POWER_ON_CHECK: begin
        if (test_done && !test_pass) begin
          nxt_mode = pmc_pkg::PMC_TEST_FAILED;
        end else if (test_done && step_ff == pmc_pkg::TEST_W'(pmc_pkg::NUM_TESTS - 1)) begin
          nxt_mode = tuned_stored ? pmc_pkg::PMC_NORMAL_CONTROL
                                  : pmc_pkg::PMC_IDLE_UNCONFIGURED;
        end else if (test_done) begin
          nxt_step = step_ff + 1'b1;
        end
      end
      pmc_pkg::PMC_TEST_FAILED: begin
        nxt_mode = mode_ff;
      end
      pmc_pkg::PMC_FATAL_ERROR_HALT: begin
        nxt_mode = mode_ff;
      end
      pmc_pkg::PMC_IDLE_UNCONFIGURED: begin
        if (cyclic_fault) begin
          nxt_mode = pmc_pkg::PMC_FATAL_ERROR_HALT;
        end else if (tune_start) begin
          nxt_mode = pmc_pkg::PMC_SELF_TUNING;
        end
      end
      pmc_pkg::PMC_SELF_TUNING: begin
        if (cyclic_fault) begin
          nxt_mode = pmc_pkg::PMC_FATAL_ERROR_HALT;
        end else if (tune_done) begin
          nxt_mode = pmc_pkg::PMC_NORMAL_CONTROL;
        end
      end
      pmc_pkg::PMC_NORMAL_CONTROL: begin
        if (cyclic_fault) begin
          nxt_mode = pmc_pkg::PMC_FATAL_ERROR_HALT;
        end else if (tune_start) begin
          nxt_mode = pmc_pkg::PMC_SELF_TUNING;
        end else if (sp_timeout && !bus_sp_in) begin
          nxt_mode = pmc_pkg::PMC_SETPOINT_LOSS_SAFE;
        end
      end
      pmc_pkg::PMC_SETPOINT_LOSS_SAFE: begin
        if (cyclic_fault) begin
          nxt_mode = pmc_pkg::PMC_FATAL_ERROR_HALT;
        end else if (bus_sp_in) begin
          nxt_mode = pmc_pkg::PMC_NORMAL_CONTROL;
        end
      end
      default: begin
        nxt_mode = pmc_pkg::PMC_POWER_ON_CHECK;
      end
    endcase
    if (factory_restore && restore_ok && !cyclic_fault) begin
      nxt_mode = pmc_pkg::PMC_IDLE_UNCONFIGURED;
    end else if (bus_sp_in && mode_ff == pmc_pkg::PMC_IDLE_UNCONFIGURED && tuned_stored) begin
      nxt_mode = pmc_pkg::PMC_NORMAL_CONTROL;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff  <= pmc_pkg::PMC_POWER_ON_CHECK;
      step_ff  <= '0;
      fcode_ff <= '0;
      tmo_ff   <= '0;
      sp_ff    <= '0;
    end else if (srst_ff) begin
      mode_ff  <= pmc_pkg::PMC_POWER_ON_CHECK;
      step_ff  <= '0;
      fcode_ff <= '0;
      tmo_ff   <= '0;
      sp_ff    <= sp_ff;
    end else begin
      mode_ff  <= nxt_mode;
      step_ff  <= nxt_step;
      fcode_ff <= (nxt_mode == pmc_pkg::PMC_TEST_FAILED && mode_ff != nxt_mode) ? step_ff : fcode_ff;
      tmo_ff   <= nxt_tmo;
      sp_ff    <= nxt_sp;
    end
  end

  // ----------------------------------------------------------------
  // Alert viewer
  // ----------------------------------------------------------------
  assign ai.pending  = alert_pending;
  assign ai.key_up   = key_rise[0] && !three_keys;
  assign ai.key_down = key_rise[1] && !three_keys;
  assign ai.key_menu = key_rise[2] && !three_keys;
  assign ai.active   = (mode_ff != pmc_pkg::PMC_POWER_ON_CHECK) && (mode_ff != pmc_pkg::PMC_FATAL_ERROR_HALT);

  pmc_alert_view u_view (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ai      (ai)
  );

  // ----------------------------------------------------------------
  // Indicators and outputs
  // ----------------------------------------------------------------
  assign blink_wrap = (blink_cnt_ff == pmc_pkg::BLINK_W'(pmc_pkg::BLINK_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else begin
      blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + 1'b1;
      blink_ff     <= blink_wrap ? !blink_ff : blink_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tuned_set_ff <= 1'b0;
      tuned_clr_ff <= 1'b0;
      red_ff       <= 1'b0;
      green_ff     <= pmc_pkg::GREEN_ALL_OFF;
      msg_ff       <= 1'b0;
      menu_ff      <= 1'b0;
      vent_ff      <= 1'b0;
      diag_ff      <= 1'b0;
      rep_ff       <= '0;
      ovr_ff       <= '0;
      ovr_act_ff   <= 1'b0;
      bin_ff       <= 2'h0;
      alarm_ff     <= 1'b0;
      ctrl_sp_ff   <= '0;
    end else begin
      tuned_set_ff <= (mode_ff == pmc_pkg::PMC_SELF_TUNING) && tune_done && !cyclic_fault;
      tuned_clr_ff <= factory_restore && restore_ok;
      if (mode_ff == pmc_pkg::PMC_FATAL_ERROR_HALT) begin
        red_ff   <= 1'b1;
        green_ff <= pmc_pkg::GREEN_ALL_OFF;
      end else if (mode_ff == pmc_pkg::PMC_POWER_ON_CHECK) begin
        red_ff   <= 1'b0;
        green_ff <= 4'h1 << step_ff[1:0];
      end else if (mode_ff == pmc_pkg::PMC_TEST_FAILED) begin
        red_ff   <= 1'b1;
        green_ff <= {1'b0, fcode_ff};
      end else begin
        red_ff   <= ai.any && blink_ff;
        green_ff <= pmc_pkg::GREEN_ALL_ON;
      end
      msg_ff   <= (mode_ff == pmc_pkg::PMC_FATAL_ERROR_HALT) || ai.any;
      menu_ff  <= (mode_ff == pmc_pkg::PMC_IDLE_UNCONFIGURED) || (ai.disp == pmc_pkg::PMC_DISP_MENU);
      vent_ff  <= (in_safe && fail_action == pmc_pkg::PMC_ACT_VENT) ||
                  (mode_ff == pmc_pkg::PMC_FATAL_ERROR_HALT);
      diag_ff  <= (mode_ff != pmc_pkg::PMC_POWER_ON_CHECK) && (mode_ff != pmc_pkg::PMC_TEST_FAILED);
      if (override_valid) begin
        ovr_ff <= override_value;
      end
      ovr_act_ff <= override_valid ? 1'b1 : (ovr_act_ff && override_enable);
      rep_ff   <= (fieldbus_variant && override_enable && ovr_act_ff) ? ovr_ff : real_position;
      bin_ff   <= {io_force_close, io_force_open};
      alarm_ff <= ai.any || (mode_ff == pmc_pkg::PMC_FATAL_ERROR_HALT);
      ctrl_sp_ff <= in_safe ? safe_sp : sp_ff;
    end
  end

  assign mode              = mode_ff;
  assign tuned_set         = tuned_set_ff;
  assign tuned_clear       = tuned_clr_ff;
  assign test_step         = step_ff;
  assign fail_code         = fcode_ff;
  assign led_red           = red_ff;
  assign led_green         = green_ff;
  assign msg_show          = msg_ff;
  assign menu_enable       = menu_ff;
  assign disp_sel          = ai.disp;
  assign alert_idx         = ai.idx;
  assign ctrl_setpoint     = ctrl_sp_ff;
  assign vent_output       = vent_ff;
  assign diag_run          = diag_ff;
  assign reported_position = rep_ff;
  assign io_bin_out        = bin_ff;
  assign io_alarm          = alarm_ff;

endmodule

//--- test/pmc_mode_ctrl_assertions.sv
// Concurrent checks on the mode controller ports.
// Assumes it is bound to every pmc_mode_ctrl instance.
`timescale 1ns/1ps
module pmc_mode_ctrl_chk (
  input wire logic               sys_clk, rstn, cyclic_fault, tuned_stored, tune_start, tune_done,
  input wire logic               factory_restore, bus_sp_valid, tuned_set, tuned_clear, led_red, menu_enable,
  input wire logic [3:0]         led_green,
  input wire pmc_pkg::pmc_mode_t mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_fatal_hold; mode == pmc_pkg::PMC_FATAL_ERROR_HALT |=>
    mode inside {pmc_pkg::PMC_FATAL_ERROR_HALT, pmc_pkg::PMC_POWER_ON_CHECK}; endproperty
  a_fatal_hold: assert property (p_fatal_hold) else $error("fatal halt left");
  property p_fail_hold; mode == pmc_pkg::PMC_TEST_FAILED |=>
    mode inside {pmc_pkg::PMC_TEST_FAILED, pmc_pkg::PMC_POWER_ON_CHECK}; endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("failed test left");
  property p_fatal_led; mode == pmc_pkg::PMC_FATAL_ERROR_HALT [*2] |-> led_red && led_green == 4'h0; endproperty
  a_fatal_led: assert property (p_fatal_led) else $error("fatal leds wrong");
  property p_idle_menu; mode == pmc_pkg::PMC_IDLE_UNCONFIGURED [*2] |-> menu_enable; endproperty
  a_idle_menu: assert property (p_idle_menu) else $error("menu off in idle");
  property p_safe_back; mode == pmc_pkg::PMC_SETPOINT_LOSS_SAFE && bus_sp_valid && !cyclic_fault |=>
    mode == pmc_pkg::PMC_NORMAL_CONTROL; endproperty
  a_safe_back: assert property (p_safe_back) else $error("no return from safe");
  property p_cyc_fault; cyclic_fault && mode inside {pmc_pkg::PMC_NORMAL_CONTROL, pmc_pkg::PMC_SETPOINT_LOSS_SAFE}
    |=> mode == pmc_pkg::PMC_FATAL_ERROR_HALT; endproperty
  a_cyc_fault: assert property (p_cyc_fault) else $error("fault not fatal");
  property p_tune_end; mode == pmc_pkg::PMC_SELF_TUNING && tune_done && !cyclic_fault |=>
    mode == pmc_pkg::PMC_NORMAL_CONTROL ##[0:1] tuned_set; endproperty
  a_tune_end: assert property (p_tune_end) else $error("tuning end wrong");
  property p_restore; factory_restore && !(mode inside {pmc_pkg::PMC_FATAL_ERROR_HALT, pmc_pkg::PMC_TEST_FAILED})
    |-> ##[1:2] tuned_clear; endproperty
  a_restore: assert property (p_restore) else $error("no tuned clear");
  property p_idle_hold; mode == pmc_pkg::PMC_IDLE_UNCONFIGURED && !tune_start && !tuned_stored && !cyclic_fault
    |=> mode inside {pmc_pkg::PMC_IDLE_UNCONFIGURED, pmc_pkg::PMC_POWER_ON_CHECK}; endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left");
endmodule
bind pmc_mode_ctrl pmc_mode_ctrl_chk u_chk (.*);

//--- test/pmc_host_model.sv
// Control system model sending fieldbus setpoints every PERIOD clocks while enabled.
// Assumes the bench drives en; released data toggles so it never looks valid.
`timescale 1ns/1ps
module pmc_host_model #(parameter int PERIOD = 8) (
  input wire logic  sys_clk, rstn, en,
  output logic      bus_sp_valid,
  output logic [15:0] bus_setpoint
);
  int          cnt;
  logic [15:0] last;
  wire         fire = en && cnt == 0;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      bus_sp_valid <= 1'b0;
      last <= 16'h0100;
      bus_setpoint <= 16'h0100;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      bus_sp_valid <= fire;
      bus_setpoint <= fire ? last : ~bus_setpoint;
      last <= last + 16'(fire);
    end
  end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the positioner mode controller.
// Assumes the host model feeds setpoints and the checker is bound to the design.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, rstn = 0, key_up = 0, key_down = 0, key_menu = 0, test_done = 0, test_pass = 0;
  logic cyclic_fault = 0, tuned_stored = 0, tune_start = 0, tune_done = 0, factory_restore = 0, host_en = 0;
  logic fieldbus_variant = 0, override_enable = 0, override_valid = 0, io_force_open = 0, io_force_close = 0;
  logic io_hold_last = 0, bus_sp_valid, tuned_set, tuned_clear, led_red, msg_show, menu_enable;
  logic vent_output, diag_run, io_alarm;
  logic [15:0] adc_setpoint = 16'h0abc, preset_position = 16'h1234, override_value = 16'h0777;
  logic [15:0] real_position = 16'h0555, bus_setpoint, ctrl_setpoint, reported_position;
  logic [31:0] sp_timeout_cycles = 32'h14;
  logic [7:0]  alert_pending = 8'h00;
  logic [2:0]  test_step, fail_code, alert_idx;
  logic [3:0]  led_green;
  logic [1:0]  io_bin_out;
  pmc_pkg::pmc_action_t fail_action = pmc_pkg::PMC_ACT_HOLD;
  pmc_pkg::pmc_mode_t   mode;
  pmc_pkg::pmc_disp_t   disp_sel;
  int fail_count = 0, cmp_count = 0;
  pmc_mode_ctrl DUT (.*);
  pmc_host_model u_host (.sys_clk(sys_clk), .rstn(rstn), .en(host_en), .bus_sp_valid(bus_sp_valid),
                         .bus_setpoint(bus_setpoint));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (tuned_set) tuned_stored <= 1'b1; else if (tuned_clear) tuned_stored <= 1'b0;
  task tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin fail_count++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end
  endtask
  task wait_mode(pmc_pkg::pmc_mode_t m);
    for (int i = 0; i < 100 && mode !== m; i++) tick();
    chk("mode", m, mode);
  endtask
  task run_tests(int fail_at);
    tick(2);
    for (int i = 0; i < 4 && i <= fail_at; i++) begin
      chk("test_step", i, test_step);
      chk("green", 16'h1 << i, led_green);
      test_pass = (i != fail_at);
      pulse(test_done);
    end
  endtask
  task keys3;
    {key_up, key_down, key_menu} = 3'h7;
    tick();
    {key_up, key_down, key_menu} = 3'h0;
    wait_mode(pmc_pkg::PMC_POWER_ON_CHECK);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin #400000; fail_count++; end_of_test(); end
  initial begin
    tick(5);
    rstn = 1'b1;
    run_tests(4);
    wait_mode(pmc_pkg::PMC_IDLE_UNCONFIGURED);
    tick(10);
    chk("menu", 1, menu_enable);
    pulse(tune_start);
    wait_mode(pmc_pkg::PMC_SELF_TUNING);
    pulse(tune_done);
    wait_mode(pmc_pkg::PMC_NORMAL_CONTROL);
    chk("analog sp", 16'h0abc, ctrl_setpoint);
    $display("start-up and tuning done");
    fieldbus_variant = 1'b1;
    host_en = 1'b1;
    override_enable = 1'b1;
    pulse(override_valid);
    tick(2);
    chk("override", 16'h0777, reported_position);
    io_force_close = 1'b1;
    alert_pending = 8'h06;
    tick(3);
    chk("alert", 1, alert_idx);
    chk("bin", 16'h2, io_bin_out);
    chk("alarm", 1, io_alarm);
    chk("msg", 1, msg_show);
    pulse(key_down);
    chk("alert", 2, alert_idx);
    pulse(key_up);
    chk("disp", pmc_pkg::PMC_DISP_MEASURED, disp_sel);
    pulse(key_menu);
    chk("disp", pmc_pkg::PMC_DISP_MENU, disp_sel);
    alert_pending = 8'h00;
    io_force_close = 1'b0;
    for (int a = 0; a < 3; a++) begin
      fail_action = pmc_pkg::pmc_action_t'(a);
      host_en = 1'b0;
      tick(10);
      chk("mode", pmc_pkg::PMC_NORMAL_CONTROL, mode);
      wait_mode(pmc_pkg::PMC_SETPOINT_LOSS_SAFE);
      tick(2);
      chk("vent", a == 1, vent_output);
      if (a == 2) chk("preset", 16'h1234, ctrl_setpoint);
      chk("diag", 1, diag_run);
      host_en = 1'b1;
      wait_mode(pmc_pkg::PMC_NORMAL_CONTROL);
    end
    $display("setpoint loss done");
    host_en = 1'b0;
    keys3();
    run_tests(4);
    wait_mode(pmc_pkg::PMC_NORMAL_CONTROL);
    pulse(factory_restore);
    tick(2);
    chk("tuned", 0, tuned_stored);
    keys3();
    run_tests(4);
    wait_mode(pmc_pkg::PMC_IDLE_UNCONFIGURED);
    $display("restore done");
    pulse(tune_start);
    pulse(tune_done);
    wait_mode(pmc_pkg::PMC_NORMAL_CONTROL);
    pulse(cyclic_fault);
    wait_mode(pmc_pkg::PMC_FATAL_ERROR_HALT);
    tick(2);
    chk("leds", 16'h0010, {led_red, led_green});
    pulse(tune_start);
    tick(5);
    chk("mode", pmc_pkg::PMC_FATAL_ERROR_HALT, mode);
    keys3();
    run_tests(2);
    wait_mode(pmc_pkg::PMC_TEST_FAILED);
    tick(10);
    chk("fail_code", 2, fail_code);
    $display("fault handling done");
    end_of_test();
  end
endmodule
